// ---- ccdrs_pkg.sv ----
// Summary of operation
// - frame mode: two fields of 775 lines
// - first field first pair, second field second
// - decimated mode reads 4 of 12 lines
// - decimated mode sums two rows per line
// - decimated frame gives exactly 258 lines
// - window output starts slot 26H or 30H
// - fast NTSC window is lines i+3 to i+108
// - window truncated at decimated line 258
package ccdrs_pkg;

   // =========================================================
   // geometry
   // =========================================================
   localparam logic [10:0] FIELD_LINES = 11'h307;
   localparam logic [10:0] FRAME_LINES = 11'h60E;
   localparam logic [10:0] DEC_LINES = 11'h102;
   localparam logic [10:0] DEC_GROUP_ROWS = 11'h00C;
   localparam logic [10:0] DEC_SUM_GAP = 11'h002;
   localparam logic [10:0] FIELD_PAIR_ROWS = 11'h004;
   localparam logic [10:0] SECOND_FIELD_OFFS = 11'h002;

   // =========================================================
   // focus window timing
   // =========================================================
   localparam logic [5:0] FAST_START_SLOT = 6'h1A;
   localparam logic [5:0] FASTEST_START_SLOT = 6'h1E;
   localparam logic [10:0] WIN_FIRST_OFFS = 11'h002;
   localparam logic [10:0] FAST_LEN_NTSC = 11'h06C;
   localparam logic [10:0] FAST_LEN_PAL = 11'h086;
   localparam logic [10:0] FASTEST_LEN_NTSC = 11'h026;
   localparam logic [10:0] FASTEST_LEN_PAL = 11'h02F;

   // =========================================================
   // types
   // =========================================================
   typedef enum logic [1:0] {
      MODE_FRAME = 2'h0,
      MODE_HIGH_RATE = 2'h1,
      MODE_FOCUS_WINDOW_FAST = 2'h2,
      MODE_FOCUS_WINDOW_FASTEST = 2'h3
   } ccdrs_mode_t;

   typedef enum logic {
      STD_NTSC = 1'h0,
      STD_PAL = 1'h1
   } ccdrs_std_t;

   typedef enum logic [1:0] {
      KIND_FIRST_FIELD_LINE_ONE = 2'h0,
      KIND_FIRST_FIELD_LINE_TWO = 2'h1,
      KIND_SECOND_FIELD_LINE_ONE = 2'h2,
      KIND_SECOND_FIELD_LINE_TWO = 2'h3
   } ccdrs_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SWEEP = 3'h1,
      ST_WAIT = 3'h2,
      ST_OUT = 3'h3,
      ST_DONE = 3'h4
   } ccdrs_state_t;

   typedef struct packed {
      logic [10:0] num;
      logic field;
      ccdrs_kind_t kind;
      logic [10:0] row_a;
      logic [10:0] row_b;
      logic summed;
   } ccdrs_line_t;

endpackage

// ---- ccdrs_line_if.sv ----
`timescale 1ns/1ps
interface ccdrs_line_if;
   logic valid;
   logic ready;
   ccdrs_pkg::ccdrs_line_t data;

   modport src (
      output valid,
      output data,
      input ready
   );

   modport snk (
      input valid,
      input data,
      output ready
   );
endinterface

// ---- ccdrs_line_buf.sv ----
`timescale 1ns/1ps
module ccdrs_line_buf (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   ccdrs_line_if.snk in_if,
   ccdrs_line_if.src out_if
);

   // entry 0 is the head seen by the receiver, entry 1 the spare
   ccdrs_pkg::ccdrs_line_t ent_q [2];
   logic [1:0] vld_q;
   logic push;
   logic pop;

   // ready depends only on the spare slot, so it never loops back
   assign in_if.ready = ~vld_q[1];
   assign out_if.valid = vld_q[0];
   assign out_if.data = ent_q[0];
   assign push = in_if.valid & ~vld_q[1];
   assign pop = vld_q[0] & out_if.ready;

   // =========================================================
   // valid flags
   // =========================================================
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         vld_q <= 2'h0;
      end else if (pop) begin
         vld_q[0] <= vld_q[1] | push;
         vld_q[1] <= 1'h0;
      end else if (push) begin
         if (!vld_q[0]) begin
            vld_q[0] <= 1'h1;
         end else begin
            vld_q[1] <= 1'h1;
         end
      end
   end

   // =========================================================
   // storage
   // =========================================================
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ent_q[0] <= '0;
         ent_q[1] <= '0;
      end else if (pop) begin
         if (vld_q[1]) begin
            ent_q[0] <= ent_q[1];
         end else if (push) begin
            ent_q[0] <= in_if.data;
         end
      end else if (push) begin
         if (!vld_q[0]) begin
            ent_q[0] <= in_if.data;
         end else begin
            ent_q[1] <= in_if.data;
         end
      end
   end

endmodule

// ---- ccdrs_readout.sv ----
`timescale 1ns/1ps
module ccdrs_readout (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic frame_start_i,
   input wire logic line_strobe_i,
   input wire logic [1:0] mode_i,
   input wire logic std_i,
   input wire logic [7:0] frame_shift_i,
   input wire logic line_ready_i,
   output logic line_valid_o,
   output logic [10:0] line_num_o,
   output logic line_field_o,
   output logic [1:0] line_kind_o,
   output logic [10:0] row_a_o,
   output logic [10:0] row_b_o,
   output logic summed_o,
   output logic sweeping_o,
   output logic frame_active_o,
   output logic line_missed_o
);

   // =========================================================
   // declarations
   // =========================================================
   ccdrs_pkg::ccdrs_state_t state_q;
   ccdrs_pkg::ccdrs_mode_t mode_q;
   logic [7:0] shift_q;
   logic [7:0] sweep_cnt_q;
   logic [5:0] slot_q;
   logic [10:0] line_q;
   logic [10:0] last_q;
   logic pend_vld_q;
   ccdrs_pkg::ccdrs_line_t pend_q;
   logic sweeping_q;
   logic active_q;
   logic missed_q;

   ccdrs_pkg::ccdrs_mode_t mode_in;
   logic focus_in;
   logic [5:0] start_slot;
   logic at_start;
   logic emit;
   logic emit_lost;
   logic pend_take;
   logic [10:0] win_first;
   logic [10:0] win_last;
   ccdrs_pkg::ccdrs_line_t word;

   ccdrs_line_if src_if ();
   ccdrs_line_if out_if ();

   assign mode_in = ccdrs_pkg::ccdrs_mode_t'(mode_i);
   assign focus_in = mode_in[1];

   // =========================================================
   // window bounds
   // =========================================================
   function automatic logic [10:0] win_len(
      input ccdrs_pkg::ccdrs_mode_t m,
      input logic s
   );
      logic [10:0] len;
      len = ccdrs_pkg::FAST_LEN_NTSC;
      if (m == ccdrs_pkg::MODE_FOCUS_WINDOW_FAST) begin
         len = s ? ccdrs_pkg::FAST_LEN_PAL : ccdrs_pkg::FAST_LEN_NTSC;
      end else begin
         len = s ? ccdrs_pkg::FASTEST_LEN_PAL : ccdrs_pkg::FASTEST_LEN_NTSC;
      end
      return len;
   endfunction

   // zero-based index i+2 is window line number i+3, lines i+1 and i+2 never leave
   assign win_first = {3'h0, frame_shift_i} + ccdrs_pkg::WIN_FIRST_OFFS;

   always_comb begin
      logic [10:0] end_line;
      end_line = {3'h0, frame_shift_i} + win_len(mode_in, std_i);
      if (end_line > ccdrs_pkg::DEC_LINES) begin
         end_line = ccdrs_pkg::DEC_LINES;
      end
      win_last = end_line - 11'h001;
   end

   assign start_slot = (mode_q == ccdrs_pkg::MODE_FOCUS_WINDOW_FAST) ?
                       ccdrs_pkg::FAST_START_SLOT : ccdrs_pkg::FASTEST_START_SLOT;

   // strobe that carries slot start_slot arrives with slot_q one below it
   assign at_start = (slot_q == (start_slot - 6'h01));

   // =========================================================
   // line word build
   // =========================================================
   always_comb begin
      logic [10:0] l;
      logic fld;
      logic [7:0] grp;
      word = '0;
      l = line_q;
      fld = 1'h0;
      grp = line_q[8:1];
      word.num = line_q + 11'h001;
      if (mode_q == ccdrs_pkg::MODE_FRAME) begin
         if (line_q >= ccdrs_pkg::FIELD_LINES) begin
            fld = 1'h1;
            l = line_q - ccdrs_pkg::FIELD_LINES;
         end
         word.field = fld;
         // each field takes its own line pair of every four-row mosaic cell
         word.row_a = (ccdrs_pkg::FIELD_PAIR_ROWS * {1'h0, l[10:1]})
                      + {10'h000, l[0]}
                      + (fld ? ccdrs_pkg::SECOND_FIELD_OFFS : 11'h000);
         word.row_b = word.row_a;
         word.kind = ccdrs_pkg::ccdrs_kind_t'({fld, l[0]});
         word.summed = 1'h0;
      end else begin
         // two output lines per twelve rows: four rows read, summed in pairs
         word.field = 1'h0;
         word.row_a = (ccdrs_pkg::DEC_GROUP_ROWS * {3'h0, grp})
                      + {10'h000, line_q[0]};
         word.row_b = word.row_a + ccdrs_pkg::DEC_SUM_GAP;
         word.kind = ccdrs_pkg::ccdrs_kind_t'({1'h0, line_q[0]});
         word.summed = 1'h1;
      end
   end

   // =========================================================
   // emit decision
   // =========================================================
   assign emit = line_strobe_i & ~frame_start_i &
                 ((state_q == ccdrs_pkg::ST_OUT) |
                  ((state_q == ccdrs_pkg::ST_WAIT) & at_start));
   assign pend_take = pend_vld_q & src_if.ready;
   // a stalled receiver cannot stop the sensor's charge, so the word is dropped
   assign emit_lost = emit & pend_vld_q & ~src_if.ready;

   // =========================================================
   // frame settings, latched once per frame
   // =========================================================
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_q <= ccdrs_pkg::MODE_FRAME;
         shift_q <= 8'h00;
      end else if (frame_start_i) begin
         // the standard only shapes the window bound, taken into last_q here as well
         mode_q <= mode_in;
         shift_q <= frame_shift_i;
      end
   end

   // =========================================================
   // sequencer
   // =========================================================
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= ccdrs_pkg::ST_IDLE;
      end else if (frame_start_i) begin
         if (focus_in) begin
            state_q <= (frame_shift_i == 8'h00) ? ccdrs_pkg::ST_WAIT : ccdrs_pkg::ST_SWEEP;
         end else begin
            state_q <= ccdrs_pkg::ST_OUT;
         end
      end else begin
         unique case (state_q)
            ccdrs_pkg::ST_IDLE: begin
               state_q <= ccdrs_pkg::ST_IDLE;
            end
            ccdrs_pkg::ST_SWEEP: begin
               if (sweep_cnt_q == shift_q - 8'h01) begin
                  state_q <= ccdrs_pkg::ST_WAIT;
               end
            end
            ccdrs_pkg::ST_WAIT: begin
               if (emit) begin
                  state_q <= (line_q == last_q) ? ccdrs_pkg::ST_DONE : ccdrs_pkg::ST_OUT;
               end
            end
            ccdrs_pkg::ST_OUT: begin
               if (emit && line_q == last_q) begin
                  state_q <= ccdrs_pkg::ST_DONE;
               end
            end
            ccdrs_pkg::ST_DONE: begin
               state_q <= ccdrs_pkg::ST_DONE;
            end
            default: begin
               state_q <= ccdrs_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // =========================================================
   // frame-shift sweep of the picture top
   // =========================================================
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sweep_cnt_q <= 8'h00;
         sweeping_q <= 1'h0;
      end else if (frame_start_i) begin
         sweep_cnt_q <= 8'h00;
         sweeping_q <= focus_in & (frame_shift_i != 8'h00);
      end else if (state_q == ccdrs_pkg::ST_SWEEP) begin
         sweep_cnt_q <= sweep_cnt_q + 8'h01;
         if (sweep_cnt_q == shift_q - 8'h01) begin
            sweeping_q <= 1'h0;
         end
      end
   end

   // =========================================================
   // line slot counter
   // =========================================================
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         slot_q <= 6'h00;
      end else if (frame_start_i) begin
         slot_q <= 6'h00;
      end else if (line_strobe_i && slot_q != 6'h3F) begin
         slot_q <= slot_q + 6'h01;
      end
   end

   // =========================================================
   // line index and bound
   // =========================================================
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         line_q <= 11'h000;
         last_q <= 11'h000;
      end else if (frame_start_i) begin
         unique case (mode_in)
            ccdrs_pkg::MODE_FRAME: begin
               line_q <= 11'h000;
               last_q <= ccdrs_pkg::FRAME_LINES - 11'h001;
            end
            ccdrs_pkg::MODE_HIGH_RATE: begin
               line_q <= 11'h000;
               last_q <= ccdrs_pkg::DEC_LINES - 11'h001;
            end
            ccdrs_pkg::MODE_FOCUS_WINDOW_FAST,
            ccdrs_pkg::MODE_FOCUS_WINDOW_FASTEST: begin
               line_q <= win_first;
               last_q <= win_last;
            end
         endcase
      end else if (emit && line_q != last_q) begin
         line_q <= line_q + 11'h001;
      end
   end

   // =========================================================
   // pending word toward the buffer
   // =========================================================
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pend_vld_q <= 1'h0;
         pend_q <= '0;
      end else if (emit && (!pend_vld_q || src_if.ready)) begin
         pend_vld_q <= 1'h1;
         pend_q <= word;
      end else if (pend_take) begin
         pend_vld_q <= 1'h0;
      end
   end

   assign src_if.valid = pend_vld_q;
   assign src_if.data = pend_q;

   // =========================================================
   // status
   // =========================================================
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         missed_q <= 1'h0;
      end else if (emit_lost) begin
         missed_q <= 1'h1;
      end else if (frame_start_i) begin
         missed_q <= 1'h0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         active_q <= 1'h0;
      end else if (frame_start_i) begin
         active_q <= 1'h1;
      end else if (state_q == ccdrs_pkg::ST_DONE || state_q == ccdrs_pkg::ST_IDLE) begin
         active_q <= 1'h0;
      end
   end

   assign sweeping_o = sweeping_q;
   assign frame_active_o = active_q;
   assign line_missed_o = missed_q;

   // =========================================================
   // output buffer
   // =========================================================
   ccdrs_line_buf u_buf (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .in_if(src_if),
      .out_if(out_if)
   );

   assign out_if.ready = line_ready_i;
   assign line_valid_o = out_if.valid;
   assign line_num_o = out_if.data.num;
   assign line_field_o = out_if.data.field;
   assign line_kind_o = out_if.data.kind;
   assign row_a_o = out_if.data.row_a;
   assign row_b_o = out_if.data.row_b;
   assign summed_o = out_if.data.summed;

endmodule

// ---- ccdrs_tg_model.sv ----
`timescale 1ns/1ps
module ccdrs_tg_model (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic go_i,
   input wire logic [11:0] lines_i,
   input wire logic [7:0] gap_i,
   output logic frame_start_o,
   output logic line_strobe_o,
   output logic busy_o
);
   logic [11:0] left_q;
   logic [7:0] tick_q;
   // ==========================================
   // frame and line slot pacing
   // ==========================================
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         frame_start_o <= 1'b0;
         line_strobe_o <= 1'b0;
         busy_o <= 1'b0;
         left_q <= 12'h000;
         tick_q <= 8'h00;
      end else begin
         frame_start_o <= 1'b0;
         line_strobe_o <= 1'b0;
         // new frame only once idle, so settings stay fixed per frame
         if (go_i && !busy_o) begin
            frame_start_o <= 1'b1;
            busy_o <= 1'b1;
            left_q <= lines_i;
            // leading idle span stands in for the register sweep before readout
            tick_q <= gap_i;
         end else if (busy_o) begin
            if (tick_q != 8'h00) begin
               tick_q <= tick_q - 8'h01;
            end else if (left_q != 12'h000) begin
               // line period scaled to gap_i+1 clocks to keep runs short
               line_strobe_o <= 1'b1;
               left_q <= left_q - 12'h001;
               tick_q <= gap_i;
            end else begin
               busy_o <= 1'b0;
            end
         end
      end
   end
endmodule

// ---- ccdrs_readout_checker.sv ----
`timescale 1ns/1ps
module ccdrs_readout_checker (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic frame_start_i,
   input wire logic line_strobe_i,
   input wire logic [1:0] mode_i,
   input wire logic std_i,
   input wire logic [7:0] frame_shift_i,
   input wire logic line_ready_i,
   input wire logic line_valid_o,
   input wire logic [10:0] line_num_o,
   input wire logic line_field_o,
   input wire logic [1:0] line_kind_o,
   input wire logic [10:0] row_a_o,
   input wire logic [10:0] row_b_o,
   input wire logic summed_o,
   input wire logic sweeping_o,
   input wire logic frame_active_o,
   input wire logic line_missed_o
);
   logic [1:0] mode_q;
   logic [7:0] shift_q;
   logic std_q;
   logic [8:0] sw_q;
   logic [10:0] k;
   logic dec;
   assign k = line_num_o - 11'h001;
   assign dec = mode_q != ccdrs_pkg::MODE_FRAME;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_q <= 2'h0;
         shift_q <= 8'h00;
         std_q <= 1'b0;
      end else if (frame_start_i) begin
         mode_q <= mode_i;
         shift_q <= frame_shift_i;
         std_q <= std_i;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sw_q <= 9'h000;
      end else if (frame_start_i) begin
         sw_q <= 9'h000;
      end else if (sweeping_o) begin
         sw_q <= sw_q + 9'h001;
      end
   end
   // ==========================================
   // properties
   // ==========================================
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   sequence s_stall; line_valid_o && !line_ready_i; endsequence
   sequence s_dec_out; line_valid_o && dec; endsequence
   sequence s_sweep_go; frame_start_i && mode_i[1] && frame_shift_i != 8'h00; endsequence
   a_stall_holds: assert property (s_stall |=> line_valid_o && $stable(line_num_o) && $stable(row_a_o))
      else $error("held word changed");
   a_start_active: assert property (frame_start_i |=> frame_active_o)
      else $error("frame not active");
   a_sweep_begins: assert property (s_sweep_go |=> sweeping_o)
      else $error("sweep missing");
   a_sweep_length: assert property ($fell(sweeping_o) && !$past(frame_start_i) |-> sw_q == {1'b0, shift_q})
      else $error("sweep length wrong");
   a_frame_rows: assert property (line_valid_o && !dec |-> !summed_o && row_b_o == row_a_o
      && line_kind_o[1] == line_field_o)
      else $error("frame row wrong");
   a_field_split: assert property (line_valid_o && !dec |-> line_field_o == (line_num_o > 11'h307)
      && line_num_o <= 11'h60E && line_num_o != 11'h000)
      else $error("field split wrong");
   a_dec_summed: assert property (s_dec_out |-> summed_o && row_b_o == row_a_o + 11'h002 && !line_field_o)
      else $error("sum pair wrong");
   a_dec_rows: assert property (s_dec_out |-> row_a_o == 11'h00C * (k >> 1) + {10'h000, k[0]})
      else $error("decimated row wrong");
   a_dec_bound: assert property (s_dec_out |-> line_num_o != 11'h000 && line_num_o <= 11'h102)
      else $error("line beyond frame");
   a_win_first: assert property (line_valid_o && mode_q[1] |-> line_num_o >= {3'h0, shift_q} + 11'h003)
      else $error("window starts early");
   a_win_last: assert property (line_valid_o && mode_q == ccdrs_pkg::MODE_FOCUS_WINDOW_FAST && !std_q
      |-> line_num_o <= {3'h0, shift_q} + 11'h06C)
      else $error("window too long");
endmodule
bind ccdrs_readout ccdrs_readout_checker u_chk (.clk_sys_i, .rstn_i, .frame_start_i, .line_strobe_i, .mode_i,
   .std_i, .frame_shift_i, .line_ready_i, .line_valid_o, .line_num_o, .line_field_o, .line_kind_o, .row_a_o,
   .row_b_o, .summed_o, .sweeping_o, .frame_active_o, .line_missed_o);

// ---- ccdrs_readout_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module ccdrs_readout_test;
   logic clk_sys_i = 1'b0;
   logic rstn_i = 1'b0;
   logic go = 1'b0;
   logic [11:0] n_lines = 12'h000;
   logic [7:0] gap = 8'h00;
   logic [1:0] mode_i = 2'h0;
   logic std_i = 1'b0;
   logic [7:0] frame_shift_i = 8'h00;
   logic line_ready_i = 1'b1;
   logic frame_start_i, line_strobe_i, tg_busy;
   logic line_valid_o, line_field_o, summed_o, sweeping_o, frame_active_o, line_missed_o;
   logic [10:0] line_num_o, row_a_o, row_b_o;
   logic [1:0] line_kind_o;
   int fail_count = 0;
   int cmp_count = 0;
   int slot = 0;
   ccdrs_pkg::ccdrs_line_t q[$];
   int q_slot[$];
   always #10 clk_sys_i = ~clk_sys_i;
   ccdrs_tg_model tg (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .go_i(go), .lines_i(n_lines), .gap_i(gap),
      .frame_start_o(frame_start_i), .line_strobe_o(line_strobe_i), .busy_o(tg_busy));
   ccdrs_readout dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .frame_start_i(frame_start_i),
      .line_strobe_i(line_strobe_i), .mode_i(mode_i), .std_i(std_i), .frame_shift_i(frame_shift_i),
      .line_ready_i(line_ready_i), .line_valid_o(line_valid_o), .line_num_o(line_num_o),
      .line_field_o(line_field_o), .line_kind_o(line_kind_o), .row_a_o(row_a_o), .row_b_o(row_b_o),
      .summed_o(summed_o), .sweeping_o(sweeping_o), .frame_active_o(frame_active_o),
      .line_missed_o(line_missed_o));
   // ==========================================
   // receiver: collects taken words with the slot they came in
   // ==========================================
   always @(posedge clk_sys_i) begin
      if (frame_start_i) slot <= 0;
      else if (line_strobe_i) slot <= slot + 1;
      if (line_valid_o === 1'b1 && line_ready_i) begin
         q.push_back({line_num_o, line_field_o, line_kind_o, row_a_o, row_b_o, summed_o});
         q_slot.push_back(slot);
      end
   end
   task automatic run(input logic [1:0] m, input logic s, input logic [7:0] i, input int n, input logic [7:0] g);
      int t;
      q.delete();
      q_slot.delete();
      @(posedge clk_sys_i);
      mode_i <= m;
      std_i <= s;
      frame_shift_i <= i;
      n_lines <= 12'(n);
      gap <= g;
      go <= 1'b1;
      @(posedge clk_sys_i);
      go <= 1'b0;
      @(posedge clk_sys_i);
      t = 0;
      while (tg_busy === 1'b1 && t < 20000) begin
         @(posedge clk_sys_i);
         t++;
      end
      if (t >= 20000) fail_count++;
      repeat (8) @(posedge clk_sys_i);
   endtask
   task automatic check_words(input logic [1:0] m, input int first, input int last);
      ccdrs_pkg::ccdrs_line_t w;
      logic [10:0] k, l, r;
      logic f, fm;
      fm = m == ccdrs_pkg::MODE_FRAME;
      `CHK("count", last - first + 1, q.size())
      foreach (q[j]) begin
         w = q[j];
         k = 11'(first + j - 1);
         f = fm && (k >= ccdrs_pkg::FIELD_LINES);
         l = f ? k - ccdrs_pkg::FIELD_LINES : k;
         r = fm ? 11'h004 * (l >> 1) + l[0] + (f ? 11'h002 : 11'h000) : 11'h00C * (k >> 1) + k[0];
         `CHK("line_num", k + 11'h001, w.num)
         `CHK("field", f, w.field)
         `CHK("kind", ({f, l[0]}), w.kind)
         `CHK("row_a", r, w.row_a)
         `CHK("row_b", (fm ? r : r + 11'h002), w.row_b)
         `CHK("summed", !fm, w.summed)
      end
   endtask
   task automatic t_frame;
      run(ccdrs_pkg::MODE_FRAME, 1'b0, 8'h00, 1552, 8'h03);
      check_words(ccdrs_pkg::MODE_FRAME, 1, 1550);
      `CHK("frame_active", 1'b0, frame_active_o)
      $display("frame readout test done");
   endtask
   task automatic t_high_rate;
      run(ccdrs_pkg::MODE_HIGH_RATE, 1'b1, 8'h00, 260, 8'h03);
      check_words(ccdrs_pkg::MODE_HIGH_RATE, 1, 258);
      `CHK("frame_active", 1'b0, frame_active_o)
      $display("high rate test done");
   endtask
   task automatic t_windows;
      int tm[4] = '{2, 2, 3, 3};
      int ti[4] = '{100, 160, 0, 250};
      int tf[4] = '{103, 163, 3, 253};
      int tl[4] = '{208, 258, 38, 258};
      int ts[4] = '{26, 26, 30, 30};
      for (int e = 0; e < 4; e++) begin
         run(2'(tm[e]), 1'(e), 8'(ti[e]), ts[e] + tl[e] - tf[e] + 2, 8'h0B);
         check_words(2'(tm[e]), tf[e], tl[e]);
         `CHK("start slot", ts[e], q_slot[0])
         `CHK("sweeping", 1'b0, sweeping_o)
      end
      $display("focus window test done");
   endtask
   task automatic t_stall;
      @(posedge clk_sys_i);
      line_ready_i <= 1'b0;
      run(ccdrs_pkg::MODE_HIGH_RATE, 1'b0, 8'h00, 10, 8'h00);
      `CHK("missed", 1'b1, line_missed_o)
      `CHK("held valid", 1'b1, line_valid_o)
      `CHK("held num", 11'h001, line_num_o)
      line_ready_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      check_words(ccdrs_pkg::MODE_HIGH_RATE, 1, 3);
      run(ccdrs_pkg::MODE_HIGH_RATE, 1'b0, 8'h00, 0, 8'h00);
      `CHK("missed cleared", 1'b0, line_missed_o)
      $display("stall test done");
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      @(posedge clk_sys_i);
      `CHK("idle valid", 1'b0, line_valid_o)
      `CHK("idle active", 1'b0, frame_active_o)
      $display("reset test done");
      t_frame();
      t_high_rate();
      t_windows();
      t_stall();
      give_verdict();
   end
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      fail_count++;
      give_verdict();
   end
endmodule
